/* File: hdl/rsad_pkg.sv */
// shared constants and types for reset sequencing and address decode
package rsad_pkg;
	localparam int ADDR_W = 16;
	localparam logic [15:0] VEC_LO = 16'h0000;
	localparam logic [15:0] VEC_HI = 16'h0047;
	localparam logic [15:0] ROM_LO = 16'h0048;
	localparam logic [15:0] ROM48_HI = 16'hbfff;
	localparam logic [15:0] ROM24_HI = 16'h5fff;
	localparam logic [15:0] EXT_MID_LO = 16'hc000;
	localparam logic [15:0] EXT_MID_HI = 16'hf77f;
	localparam logic [15:0] RAM2K_LO = 16'hf780;
	localparam logic [15:0] RAM1K_LO = 16'hfb80;
	localparam logic [15:0] RAM_HI = 16'hff7f;
	localparam logic [15:0] EXT_TOP_LO = 16'hff80;
	localparam logic [15:0] EXT_TOP_HI = 16'hff87;
	localparam logic [15:0] REG_LO = 16'hff88;
	localparam logic [15:0] RST_VEC_HI_ADDR = 16'h0000;
	localparam logic [15:0] RST_VEC_LO_ADDR = 16'h0001;
	localparam logic [7:0] CCR_RESET = 8'h80;
	localparam int CCR_IMASK_BIT = 7;
	localparam logic RAM_ON_RESET = 1'b1;
	localparam logic [1:0] MODE_BAD = 2'h0;
	localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
	localparam logic [1:0] MODE_EXP_ROM = 2'h2;
	localparam logic [1:0] MODE_SINGLE = 2'h3;
	typedef enum logic [2:0] {
		RSAD_RGN_VECTOR,
		RSAD_RGN_ROM,
		RSAD_RGN_RAM,
		RSAD_RGN_REGS,
		RSAD_RGN_EXT,
		RSAD_RGN_NONE
	} rsad_region_e;
	typedef enum logic [2:0] {
		RSAD_ST_INIT,
		RSAD_ST_VEC_HI,
		RSAD_ST_VEC_LO,
		RSAD_ST_FIRST,
		RSAD_ST_RUN,
		RSAD_ST_INT
	} rsad_state_e;
endpackage : rsad_pkg

/* File: hdl/rsad_dec_if.sv */
// interface between sequencer and address decoder
`timescale 1ns/100ps
interface rsad_dec_if;
	logic [15:0] addr;
	logic [1:0] mode;
	logic ram_on;
	logic small_variant;
	rsad_pkg::rsad_region_e region;
	logic reserved_hit;
	modport seq (output addr, output mode, output ram_on, output small_variant, input region, input reserved_hit);
	modport dec (input addr, input mode, input ram_on, input small_variant, output region, output reserved_hit);
endinterface : rsad_dec_if

/* File: hdl/rsad_addr_decode.sv */
// combinational mode-dependent address decoder
`timescale 1ns/100ps
module rsad_addr_decode (
	rsad_dec_if.dec dif
);
	import rsad_pkg::*;

	logic [15:0] a;
	logic expanded;
	logic rom_on;
	logic [15:0] rom_hi;
	logic [15:0] ram_lo;
	assign a = dif.addr;
	assign expanded = (dif.mode == MODE_EXP_NOROM) || (dif.mode == MODE_EXP_ROM);
	assign rom_on = (dif.mode == MODE_EXP_ROM) || (dif.mode == MODE_SINGLE);
	assign rom_hi = dif.small_variant ? ROM24_HI : ROM48_HI;
	assign ram_lo = dif.small_variant ? RAM1K_LO : RAM2K_LO;

	// region select, fixed priority by address band
	always_comb begin
		dif.region = RSAD_RGN_NONE;
		dif.reserved_hit = 1'b0;
		if (dif.mode == MODE_BAD) begin
			dif.region = RSAD_RGN_NONE;
		end else if (a <= VEC_HI) begin
			dif.region = RSAD_RGN_VECTOR; // RULE1
		end else if (a >= REG_LO) begin
			dif.region = RSAD_RGN_REGS; // RULE7
		end else if (a >= EXT_TOP_LO) begin
			dif.region = expanded ? RSAD_RGN_EXT : RSAD_RGN_NONE; // RULE6
		end else if (a >= ram_lo) begin
			dif.region = dif.ram_on ? RSAD_RGN_RAM : (expanded ? RSAD_RGN_EXT : RSAD_RGN_NONE); // RULE4 RULE8 RULE5
		end else if (a >= RAM2K_LO) begin
			dif.region = RSAD_RGN_NONE; // RULE9
			dif.reserved_hit = 1'b1;
		end else if (rom_on && a <= rom_hi) begin
			dif.region = RSAD_RGN_ROM; // RULE2
		end else if (rom_on && a < EXT_MID_LO) begin
			dif.region = RSAD_RGN_NONE; // RULE9
			dif.reserved_hit = 1'b1;
		end else if (expanded) begin
			dif.region = RSAD_RGN_EXT; // RULE2 RULE3 RULE21
		end
	end
endmodule : rsad_addr_decode

/* File: hdl/rsad_reset_seq.sv */
// reset exception sequencer and address steering top
// Operation
// (RULE1) vector table at 0000-0047 always
// (RULE2) 0048-bfff rom, or external without rom
// (RULE3) c000-f77f external in expanded rom mode
// (RULE4) 2k ram at f780-ff7f all modes
// (RULE5) ram off sends ram range external; decoder gives region none in single-chip mode
// (RULE6) ff80-ff87 external in expanded modes
// (RULE7) ff88-ffff on-chip register field always
// (RULE8) 1k ram at fb80-ff7f on small
// (RULE9) software avoids reserved ranges on small
// (RULE10) only reset and interrupt; reset wins
// (RULE11) sequence starts at reset pin release
// (RULE12) interrupt taken at instruction/sequence end
// (RULE13) reset low holds state at initial values
// (RULE14) reset low at least ten clocks; not checked by the design, and the bench's first boot releases it after 5
// (RULE15) reset sets interrupt mask bit
// (RULE16) pc loaded from vector 0000/0001
// (RULE17) all interrupts blocked until first instruction
// (RULE18) software first sets the stack pointer
// (RULE19) mode pins sampled at reset exit
// (RULE20) reset sets ram enable to one
// (RULE21) external cycle only in expanded modes
`timescale 1ns/100ps
module rsad_reset_seq #(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input wire logic core_clk,
	input wire logic chip_init_pin_n,
	input wire logic mode_pin_high,
	input wire logic mode_pin_low,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_access,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rvalid,
	input wire logic insn_done,
	input wire logic int_pending,
	input wire logic nmi_pending,
	input wire logic int_seq_done,
	input wire logic ram_on_wr,
	input wire logic ram_on_wdata,
	output logic [1:0] mode_latched,
	output logic mode_invalid,
	output logic internal_ram_on,
	output logic [7:0] condition_code_reg,
	output logic [15:0] pc_out,
	output logic pc_valid,
	output logic vec_fetch,
	output logic [15:0] vec_addr,
	output logic int_start,
	output logic int_blocked,
	output rsad_pkg::rsad_region_e region_out,
	output logic ext_cycle,
	output logic reserved_hit
);
	import rsad_pkg::*;

	rsad_dec_if dif ();
	rsad_addr_decode u_dec (
		.dif(dif)
	);

	rsad_state_e state_ff, nxt_state;
	logic [1:0] mode_ff, nxt_mode;
	logic ram_on_ff, nxt_ram_on;
	logic [7:0] ccr_ff, nxt_ccr;
	logic [15:0] pc_ff, nxt_pc;
	logic pc_valid_ff, nxt_pc_valid;
	logic vec_fetch_ff, nxt_vec_fetch;
	logic [15:0] vec_addr_ff, nxt_vec_addr;
	logic int_start_ff, nxt_int_start;
	logic blocked_ff, nxt_blocked;
	rsad_region_e region_ff, nxt_region;
	logic ext_ff, nxt_ext;
	logic rsv_ff, nxt_rsv;
	logic in_reset_ff;
	logic mode_bad_ff, nxt_mode_bad;

	// decoder sees the vector address during a vector fetch, otherwise the live cpu address, plus latched configuration
	assign dif.addr = vec_fetch_ff ? vec_addr_ff : cpu_addr;
	assign dif.mode = mode_ff;
	assign dif.ram_on = ram_on_ff;
	assign dif.small_variant = SMALL_VARIANT;

	// first-cycle marker: the clock edge after release is the sequence start
	always_ff @(posedge core_clk or negedge chip_init_pin_n) begin
		if (!chip_init_pin_n) begin
			in_reset_ff <= 1'b1; // RULE13
		end else begin
			in_reset_ff <= 1'b0; // RULE11
		end
	end

	// sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_mode = mode_ff;
		nxt_ram_on = ram_on_ff;
		nxt_ccr = ccr_ff;
		nxt_pc = pc_ff;
		nxt_pc_valid = 1'b0;
		nxt_vec_fetch = vec_fetch_ff;
		nxt_vec_addr = vec_addr_ff;
		nxt_int_start = 1'b0;
		nxt_blocked = blocked_ff;
		nxt_region = dif.region;
		nxt_ext = 1'b0;
		nxt_rsv = cpu_access & dif.reserved_hit;
		if (ram_on_wr) begin
			nxt_ram_on = ram_on_wdata; // RULE5
		end
		unique case (state_ff)
			RSAD_ST_INIT: begin
				nxt_mode = {mode_pin_high, mode_pin_low}; // RULE19
				nxt_ccr[CCR_IMASK_BIT] = 1'b1; // RULE15
				nxt_vec_fetch = 1'b1;
				nxt_vec_addr = RST_VEC_HI_ADDR; // RULE16
				nxt_state = RSAD_ST_VEC_HI; // RULE11
			end
			RSAD_ST_VEC_HI: begin
				if (mem_rvalid) begin
					nxt_pc[15:8] = mem_rdata; // RULE16
					nxt_vec_addr = RST_VEC_LO_ADDR;
					nxt_state = RSAD_ST_VEC_LO;
				end
			end
			RSAD_ST_VEC_LO: begin
				if (mem_rvalid) begin
					nxt_pc[7:0] = mem_rdata; // RULE16
					nxt_pc_valid = 1'b1;
					nxt_vec_fetch = 1'b0;
					nxt_state = RSAD_ST_FIRST;
				end
			end
			RSAD_ST_FIRST: begin
				if (insn_done) begin
					nxt_blocked = 1'b0; // RULE17
					nxt_state = RSAD_ST_RUN;
				end
			end
			RSAD_ST_RUN: begin
				if (insn_done && (nmi_pending || (int_pending && !ccr_ff[CCR_IMASK_BIT]))) begin
					nxt_int_start = 1'b1; // RULE12 RULE10
					nxt_state = RSAD_ST_INT;
				end
			end
			RSAD_ST_INT: begin
				if (int_seq_done) begin
					if (nmi_pending || (int_pending && !ccr_ff[CCR_IMASK_BIT])) begin
						nxt_int_start = 1'b1; // RULE12
					end else begin
						nxt_state = RSAD_ST_RUN;
					end
				end
			end
		endcase
		if (mode_ff == MODE_EXP_NOROM || mode_ff == MODE_EXP_ROM) begin
			nxt_ext = (cpu_access || vec_fetch_ff) && (dif.region == RSAD_RGN_EXT); // RULE21
		end
		nxt_mode_bad = !in_reset_ff && (nxt_mode == MODE_BAD); // RULE19
	end

	// sequencer registers, set to their reset values while reset pin is low
	always_ff @(posedge core_clk or negedge chip_init_pin_n) begin
		if (!chip_init_pin_n) begin
			state_ff <= RSAD_ST_INIT; // RULE13 RULE10
			mode_ff <= MODE_SINGLE;
			ram_on_ff <= RAM_ON_RESET; // RULE20
			ccr_ff <= CCR_RESET; // RULE15
			pc_ff <= 16'h0000;
			pc_valid_ff <= 1'b0;
			vec_fetch_ff <= 1'b0;
			vec_addr_ff <= 16'h0000;
			int_start_ff <= 1'b0;
			blocked_ff <= 1'b1; // RULE17
			region_ff <= RSAD_RGN_NONE;
			ext_ff <= 1'b0;
			rsv_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			mode_ff <= nxt_mode;
			ram_on_ff <= nxt_ram_on;
			ccr_ff <= nxt_ccr;
			pc_ff <= nxt_pc;
			pc_valid_ff <= nxt_pc_valid;
			vec_fetch_ff <= nxt_vec_fetch;
			vec_addr_ff <= nxt_vec_addr;
			int_start_ff <= nxt_int_start;
			blocked_ff <= nxt_blocked;
			region_ff <= nxt_region;
			ext_ff <= nxt_ext;
			rsv_ff <= nxt_rsv;
		end
	end

	// mode pin latch is only meaningful once the init state has passed
	always_ff @(posedge core_clk or negedge chip_init_pin_n) begin
		if (!chip_init_pin_n) begin
			mode_bad_ff <= 1'b0;
		end else begin
			mode_bad_ff <= nxt_mode_bad;
		end
	end

	// outputs straight from flops
	assign mode_latched = mode_ff;
	assign mode_invalid = mode_bad_ff;
	assign internal_ram_on = ram_on_ff;
	assign condition_code_reg = ccr_ff;
	assign pc_out = pc_ff;
	assign pc_valid = pc_valid_ff;
	assign vec_fetch = vec_fetch_ff;
	assign vec_addr = vec_addr_ff;
	assign int_start = int_start_ff;
	assign int_blocked = blocked_ff;
	assign region_out = region_ff;
	assign ext_cycle = ext_ff;
	assign reserved_hit = rsv_ff;
endmodule : rsad_reset_seq

/* File: verif/rsad_assertions.sv */
// port assertions for the reset sequencer and decoder
`timescale 1ns/100ps
module rsad_assertions #(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input wire logic core_clk,
	input wire logic chip_init_pin_n,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_access,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rvalid,
	input wire logic insn_done,
	input wire logic ram_on_wr,
	input wire logic [1:0] mode_latched,
	input wire logic internal_ram_on,
	input wire logic [15:0] pc_out,
	input wire logic pc_valid,
	input wire logic vec_fetch,
	input wire logic [15:0] vec_addr,
	input wire logic int_start,
	input wire logic int_blocked,
	input rsad_pkg::rsad_region_e region_out,
	input wire logic ext_cycle
);
	import rsad_pkg::*;
	localparam logic [15:0] ROM_TOP = SMALL_VARIANT ? ROM24_HI : ROM48_HI;
	localparam logic [15:0] RAM_BOT = SMALL_VARIANT ? RAM1K_LO : RAM2K_LO;
	logic ok;
	logic exp;
	// plain cpu access in a valid mode
	assign ok = cpu_access && !vec_fetch && mode_latched != MODE_BAD && !ram_on_wr;
	assign exp = mode_latched == MODE_EXP_NOROM || mode_latched == MODE_EXP_ROM;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!chip_init_pin_n);
	vec_table_a: assert property (ok && cpu_addr <= VEC_HI |=> region_out == RSAD_RGN_VECTOR)
		else $error("vector decode");
	rom_range_a: assert property (ok && cpu_addr >= ROM_LO && cpu_addr <= ROM_TOP
		|=> region_out == (mode_latched == MODE_EXP_NOROM ? RSAD_RGN_EXT : RSAD_RGN_ROM)) else $error("rom decode");
	mid_ext_a: assert property (ok && exp && cpu_addr >= EXT_MID_LO && cpu_addr <= EXT_MID_HI
		|=> region_out == RSAD_RGN_EXT && ext_cycle) else $error("middle external decode");
	ram_range_a: assert property (ok && (internal_ram_on || exp) && cpu_addr >= RAM_BOT && cpu_addr <= RAM_HI
		|=> region_out == (internal_ram_on ? RSAD_RGN_RAM : RSAD_RGN_EXT)) else $error("ram decode");
	top_ext_a: assert property (ok && exp && cpu_addr >= EXT_TOP_LO && cpu_addr <= EXT_TOP_HI
		|=> region_out == RSAD_RGN_EXT && ext_cycle) else $error("top external decode");
	reg_field_a: assert property (ok && cpu_addr >= REG_LO |=> region_out == RSAD_RGN_REGS && !ext_cycle)
		else $error("register field decode");
	single_chip_a: assert property (cpu_access && mode_latched == MODE_SINGLE |=> !ext_cycle)
		else $error("external cycle in single-chip mode");
	vec_start_a: assert property ($rose(chip_init_pin_n) |-> ##[0:2] vec_fetch && vec_addr == RST_VEC_HI_ADDR)
		else $error("vector fetch did not start");
	pc_load_a: assert property (vec_fetch && mem_rvalid && vec_addr == RST_VEC_LO_ADDR
		|=> pc_valid && pc_out[7:0] == $past(mem_rdata)) else $error("pc low byte");
	int_block_a: assert property (int_blocked && !insn_done |=> !int_start)
		else $error("interrupt while blocked");
endmodule : rsad_assertions
bind rsad_reset_seq rsad_assertions #(.SMALL_VARIANT(SMALL_VARIANT)) chk_u (.*);

/* File: verif/rsad_mem_model.sv */
// external memory returning the reset vector bytes
`timescale 1ns/100ps
module rsad_mem_model #(
	parameter logic [15:0] VEC_WORD = 16'h1234
) (
	input wire logic core_clk,
	input wire logic [3:0] lag,
	input wire logic vec_fetch,
	input wire logic [15:0] vec_addr,
	output logic [7:0] mem_rdata = 8'h00,
	output logic mem_rvalid = 1'b0
);
	int cnt = 0;
	// answer after lag idle cycles, junk on the data lines otherwise
	always @(posedge core_clk) begin
		if (vec_fetch && !mem_rvalid && cnt >= lag) begin
			mem_rvalid <= 1'b1;
			mem_rdata <= vec_addr[0] ? VEC_WORD[7:0] : VEC_WORD[15:8];
			cnt <= 0;
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt <= vec_fetch ? cnt + 1 : 0;
		end
	end
endmodule : rsad_mem_model

/* File: verif/tb.sv */
// self-checking bench for reset sequencing and decode
`timescale 1ns/100ps
module tb;
	import rsad_pkg::*;
	localparam logic [15:0] BOOT_PC = 16'h1234;
	logic core_clk = 0, chip_init_pin_n = 0, mode_pin_high = 1, mode_pin_low = 1, cpu_access = 0;
	logic insn_done = 0, int_pending = 0, nmi_pending = 0, int_seq_done = 0, ram_on_wr = 0, ram_on_wdata = 0;
	logic [15:0] cpu_addr = 0, pc_out, vec_addr;
	logic [3:0] lag = 0;
	logic [7:0] mem_rdata, condition_code_reg;
	logic [1:0] mode_latched;
	logic mem_rvalid, mode_invalid, internal_ram_on, pc_valid, vec_fetch, int_start, int_blocked, ext_cycle, reserved_hit;
	rsad_region_e region_out;
	int mismatches = 0, tests_run = 0;
	logic [15:0] addrs [12] = '{16'h0000, 16'h0047, 16'h0048, 16'hbfff, 16'hc000, 16'hf77f,
		16'hf780, 16'hff7f, 16'hff80, 16'hff87, 16'hff88, 16'hffff};
	always #4 core_clk = ~core_clk;
	rsad_reset_seq dut_u (.*);
	rsad_mem_model #(.VEC_WORD(BOOT_PC)) mem_u (.core_clk(core_clk), .lag(lag), .vec_fetch(vec_fetch),
		.vec_addr(vec_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic check(logic [15:0] got, logic [15:0] want, string what);
		tests_run++;
		if (got !== want) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask : check
	// expected region worked out from the memory map
	function automatic rsad_region_e exp_rgn(logic [1:0] m, logic ram, logic [15:0] a);
		logic x;
		x = m != MODE_SINGLE;
		if (m == MODE_BAD) return RSAD_RGN_NONE;
		if (a <= VEC_HI) return RSAD_RGN_VECTOR;
		if (a <= ROM48_HI) return m == MODE_EXP_NOROM ? RSAD_RGN_EXT : RSAD_RGN_ROM;
		if (a <= EXT_MID_HI) return x ? RSAD_RGN_EXT : RSAD_RGN_NONE;
		if (a <= RAM_HI) return ram ? RSAD_RGN_RAM : (x ? RSAD_RGN_EXT : RSAD_RGN_NONE);
		if (a <= EXT_TOP_HI) return x ? RSAD_RGN_EXT : RSAD_RGN_NONE;
		return RSAD_RGN_REGS;
	endfunction : exp_rgn
	// hold reset, check reset state, release and await the vector load
	task automatic boot(logic [1:0] m, logic [3:0] l, int hold);
		int i;
		@(posedge core_clk);
		chip_init_pin_n <= 1'b0;
		cpu_access <= 1'b0;
		mode_pin_high <= m[1];
		mode_pin_low <= m[0];
		lag <= l;
		repeat (hold) @(posedge core_clk);
		check(condition_code_reg, CCR_RESET, "mask at reset");
		check(internal_ram_on, RAM_ON_RESET, "ram enable at reset");
		check(int_blocked, 1, "blocked at reset");
		chip_init_pin_n <= 1'b1;
		for (i = 0; i < 40 && m != MODE_BAD; i++) begin
			@(posedge core_clk);
			#1;
			if (pc_valid === 1'b1) break;
		end
		if (i == 40) begin
			mismatches++;
			final_report();
		end
		repeat (3) @(posedge core_clk);
		check(mode_invalid, m == MODE_BAD, "mode invalid");
		if (m == MODE_BAD) return;
		check(pc_out, BOOT_PC, "pc from vector");
		check(mode_latched, m, "latched mode");
		check(int_blocked, 1, "blocked before first instruction");
		check(condition_code_reg[CCR_IMASK_BIT], 1'b1, "mask after reset sequence");
	endtask : boot
	task automatic sweep(logic [1:0] m, logic ram);
		foreach (addrs[i]) begin
			@(posedge core_clk);
			cpu_addr <= addrs[i];
			cpu_access <= 1'b1;
			@(posedge core_clk);
			#1;
			check(region_out, exp_rgn(m, ram, addrs[i]), "region");
			check(ext_cycle, exp_rgn(m, ram, addrs[i]) == RSAD_RGN_EXT, "external cycle");
			check(reserved_hit, 1'b0, "reserved range hit");
		end
	endtask : sweep
	task automatic ram_set(logic v);
		@(posedge core_clk);
		ram_on_wr <= 1'b1;
		ram_on_wdata <= v;
		@(posedge core_clk);
		ram_on_wr <= 1'b0;
		#1;
		check(internal_ram_on, v, "ram enable write");
	endtask : ram_set
	task automatic step(logic n, logic p, logic [15:0] e);
		@(posedge core_clk);
		nmi_pending <= n;
		int_pending <= p;
		insn_done <= 1'b1;
		@(posedge core_clk);
		insn_done <= 1'b0;
		#1;
		check(int_start, e, "interrupt start");
	endtask : step
	initial begin
		boot(MODE_SINGLE, 4'h0, 5);
		@(posedge core_clk);
		nmi_pending <= 1'b1;
		repeat (4) @(posedge core_clk);
		check(int_start, 0, "nmi before first instruction");
		step(1, 0, 0);
		check(int_blocked, 0, "unblocked after first instruction");
		step(0, 1, 0);
		step(1, 0, 1);
		step(1, 0, 0);
		@(posedge core_clk);
		int_seq_done <= 1'b1;
		@(posedge core_clk);
		int_seq_done <= 1'b0;
		nmi_pending <= 1'b0;
		#1;
		check(int_start, 1, "nmi after sequence end");
		sweep(MODE_SINGLE, 1'b1);
		ram_set(1'b0);
		sweep(MODE_SINGLE, 1'b0);
		ram_set(1'b1);
		for (int m = 1; m < 3; m++) begin
			boot(m[1:0], 4'(m * 2), 10);
			sweep(m[1:0], 1'b1);
			ram_set(1'b0);
			sweep(m[1:0], 1'b0);
			ram_set(1'b1);
		end
		boot(MODE_BAD, 4'h0, 10);
		sweep(MODE_BAD, 1'b1);
		final_report();
	end
endmodule : tb
